// ==== design/lcc_pkg.sv ====
// Package for the ladder contact combiner: opcodes, field widths, reset values.
// Assumes a single scan clock and one instruction per step.
package lcc_pkg;

  localparam int unsigned ADDR_W = 11;
  localparam int unsigned TC_VAL_W = 16;
  // Timer/counter addresses are octal 600-677
  localparam logic [10:0] TC_ADDR_LO = 11'h180;
  localparam logic [10:0] TC_ADDR_HI = 11'h1BF;
  localparam logic RUNG_RST = 1'b0;
  localparam logic [1:0] VARIANT_FULL_A = 2'h0;
  localparam logic [1:0] VARIANT_FULL_B = 2'h1;
  localparam logic [1:0] VARIANT_REDUCED = 2'h2;

  typedef enum logic [3:0] {
    LCC_OP_NOP = 4'h0,
    LCC_OP_RUNG_LOAD = 4'h1,
    LCC_OP_PAR = 4'h2,
    LCC_OP_PAR_INV = 4'h3,
    LCC_OP_PAR_TMR = 4'h4,
    LCC_OP_PAR_INV_TMR = 4'h5,
    LCC_OP_PAR_CNT = 4'h6,
    LCC_OP_PAR_INV_CNT = 4'h7,
    LCC_OP_SER = 4'h8,
    LCC_OP_SER_INV = 4'h9,
    LCC_OP_SER_TMR = 4'hA,
    LCC_OP_SER_INV_TMR = 4'hB,
    LCC_OP_SER_CNT = 4'hC,
    LCC_OP_SER_INV_CNT = 4'hD,
    LCC_OP_COIL = 4'hE
  } lcc_op_t;

  typedef struct packed {
    logic valid;
    lcc_op_t op;
    logic [10:0] addr;
  } lcc_instr_t;

  typedef struct packed {
    logic bit_val;
    logic [15:0] cur;
    logic [15:0] preset;
  } lcc_operand_t;

  typedef struct packed {
    logic valid;
    logic [10:0] addr;
    logic data;
  } lcc_write_t;

endpackage

// ==== design/lcc_contact_eval.sv ====
// Contact evaluator: forms one contact level from an image bit or a
// timer/counter comparison. Pure combinational, same clock as its user.
`timescale 1ns/1ps
module lcc_contact_eval #(
  parameter int unsigned VAL_W = 16
) (
  // Selection
  input wire logic use_tc_i,
  input wire logic invert_i,
  // Operands
  input wire logic bit_i,
  input wire logic [VAL_W-1:0] cur_i,
  input wire logic [VAL_W-1:0] preset_i,
  // Result
  output logic contact_o
);

  logic reached;

  always_comb
  begin
    // Done when current value has reached the preset
    reached = (cur_i >= preset_i);
    contact_o = (use_tc_i ? reached : bit_i) ^ invert_i;
  end

endmodule

// ==== design/lcc_combiner.sv ====
// Ladder contact combiner: single-bit rung result updated by contact opcodes.
// Assumes the sequencer presents operands with the instruction in one cycle.
// What this block does
// - Parallel-inverted: OR complement of image bit into rung result.
// - Parallel-timer: OR in timer contact, on when current >= preset.
// - Parallel-inverted-timer: OR in contact on when timer current < preset.
// - Parallel-counter: OR in counter contact, on when current >= preset.
// - Parallel-inverted-counter: OR in contact on when counter current < preset.
// - Series: AND uninverted image bit with rung result.
// - Series-inverted: AND complement of image bit with rung result.
// - Series-timer: AND in timer contact, on when current >= preset.
// - Timer/counter opcodes only on the two larger variants.
// - Rung load puts uninverted image bit in as initial rung result.
// - Coil opcode writes final rung result into addressed image bit.
`timescale 1ns/1ps
module lcc_combiner #(
  parameter logic [1:0] VARIANT = lcc_pkg::VARIANT_FULL_B
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Instruction from sequencer
  input wire lcc_pkg::lcc_instr_t instr_i,
  // Operands from image table and timer/counter store
  input wire lcc_pkg::lcc_operand_t operand_i,
  // Results
  output logic rung_o,
  output lcc_pkg::lcc_write_t wr_o,
  output logic illegal_o
);

  localparam bit HAS_TC = (VARIANT != lcc_pkg::VARIANT_REDUCED);

  logic rung_q;
  logic rung_d;
  lcc_pkg::lcc_write_t wr_q;
  lcc_pkg::lcc_write_t wr_d;
  logic illegal_q;
  logic illegal_d;
  logic use_tc;
  logic invert;
  logic contact;
  logic tc_addr_ok;

  function automatic logic is_tc_op(input lcc_pkg::lcc_op_t op);
    unique case (op)
      lcc_pkg::LCC_OP_PAR_TMR, lcc_pkg::LCC_OP_PAR_INV_TMR,
      lcc_pkg::LCC_OP_PAR_CNT, lcc_pkg::LCC_OP_PAR_INV_CNT,
      lcc_pkg::LCC_OP_SER_TMR, lcc_pkg::LCC_OP_SER_INV_TMR,
      lcc_pkg::LCC_OP_SER_CNT, lcc_pkg::LCC_OP_SER_INV_CNT: is_tc_op = 1'b1;
      default: is_tc_op = 1'b0;
    endcase
  endfunction

  function automatic logic is_inv_op(input lcc_pkg::lcc_op_t op);
    unique case (op)
      lcc_pkg::LCC_OP_PAR_INV, lcc_pkg::LCC_OP_PAR_INV_TMR,
      lcc_pkg::LCC_OP_PAR_INV_CNT, lcc_pkg::LCC_OP_SER_INV,
      lcc_pkg::LCC_OP_SER_INV_TMR, lcc_pkg::LCC_OP_SER_INV_CNT: is_inv_op = 1'b1;
      default: is_inv_op = 1'b0;
    endcase
  endfunction

  always_comb
  begin
    use_tc = is_tc_op(instr_i.op);
    invert = is_inv_op(instr_i.op);
    tc_addr_ok = (instr_i.addr >= lcc_pkg::TC_ADDR_LO) && (instr_i.addr <= lcc_pkg::TC_ADDR_HI);
  end

  lcc_contact_eval #(
    .VAL_W(lcc_pkg::TC_VAL_W)
  ) u_eval (
    .use_tc_i(use_tc),
    .invert_i(invert),
    .bit_i(operand_i.bit_val),
    .cur_i(operand_i.cur),
    .preset_i(operand_i.preset),
    .contact_o(contact)
  );

  always_comb
  begin
    rung_d = rung_q;
    wr_d = '0;
    illegal_d = 1'b0;
    if (instr_i.valid)
    begin
      if (use_tc && (!HAS_TC || !tc_addr_ok))
      begin
        // Unsupported or out-of-range: rung result left alone, flagged instead
        illegal_d = 1'b1;
      end
      else
      begin
        unique case (instr_i.op)
          lcc_pkg::LCC_OP_RUNG_LOAD: rung_d = operand_i.bit_val;
          lcc_pkg::LCC_OP_PAR, lcc_pkg::LCC_OP_PAR_INV: rung_d = rung_q | contact;
          lcc_pkg::LCC_OP_PAR_TMR, lcc_pkg::LCC_OP_PAR_INV_TMR: rung_d = rung_q | contact;
          lcc_pkg::LCC_OP_PAR_CNT, lcc_pkg::LCC_OP_PAR_INV_CNT: rung_d = rung_q | contact;
          lcc_pkg::LCC_OP_SER, lcc_pkg::LCC_OP_SER_INV: rung_d = rung_q & contact;
          lcc_pkg::LCC_OP_SER_TMR, lcc_pkg::LCC_OP_SER_INV_TMR,
          lcc_pkg::LCC_OP_SER_CNT, lcc_pkg::LCC_OP_SER_INV_CNT: rung_d = rung_q & contact;
          lcc_pkg::LCC_OP_COIL:
          begin
            wr_d.valid = 1'b1;
            wr_d.addr = instr_i.addr;
            wr_d.data = rung_q;
          end
          default: rung_d = rung_q; // NOP and unused codes
        endcase
      end
    end
  end

  // Single step update; image writes only come from the coil opcode
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rung_q <= lcc_pkg::RUNG_RST;
      wr_q <= '0;
      illegal_q <= 1'b0;
    end
    else
    begin
      rung_q <= rung_d;
      wr_q <= wr_d;
      illegal_q <= illegal_d;
    end
  end

  assign rung_o = rung_q;
  assign wr_o = wr_q;
  assign illegal_o = illegal_q;

  par_inv_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    instr_i.valid && instr_i.op == lcc_pkg::LCC_OP_PAR_INV
    |=> rung_q == ($past(rung_q) | !$past(operand_i.bit_val)))
    else $error("parallel inverted result wrong");
  par_tmr_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    instr_i.valid && instr_i.op == lcc_pkg::LCC_OP_PAR_TMR && HAS_TC && tc_addr_ok
    |=> rung_q == ($past(rung_q) | ($past(operand_i.cur) >= $past(operand_i.preset))))
    else $error("parallel timer result wrong");
  par_inv_tmr_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    instr_i.valid && instr_i.op == lcc_pkg::LCC_OP_PAR_INV_TMR && HAS_TC && tc_addr_ok
    |=> rung_q == ($past(rung_q) | ($past(operand_i.cur) < $past(operand_i.preset))))
    else $error("parallel inverted timer result wrong");
  par_cnt_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    instr_i.valid && instr_i.op == lcc_pkg::LCC_OP_PAR_CNT && HAS_TC && tc_addr_ok
    |=> rung_q == ($past(rung_q) | ($past(operand_i.cur) >= $past(operand_i.preset))))
    else $error("parallel counter result wrong");
  par_inv_cnt_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    instr_i.valid && instr_i.op == lcc_pkg::LCC_OP_PAR_INV_CNT && HAS_TC && tc_addr_ok
    |=> rung_q == ($past(rung_q) | ($past(operand_i.cur) < $past(operand_i.preset))))
    else $error("parallel inverted counter result wrong");
  ser_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    instr_i.valid && instr_i.op == lcc_pkg::LCC_OP_SER
    |=> rung_q == ($past(rung_q) & $past(operand_i.bit_val)))
    else $error("series result wrong");
  ser_inv_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    instr_i.valid && instr_i.op == lcc_pkg::LCC_OP_SER_INV
    |=> rung_q == ($past(rung_q) & !$past(operand_i.bit_val)))
    else $error("series inverted result wrong");
  ser_tmr_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    instr_i.valid && instr_i.op == lcc_pkg::LCC_OP_SER_TMR && HAS_TC && tc_addr_ok
    |=> rung_q == ($past(rung_q) & ($past(operand_i.cur) >= $past(operand_i.preset))))
    else $error("series timer result wrong");
  tc_gate_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    instr_i.valid && use_tc && !HAS_TC |=> illegal_o && $stable(rung_q))
    else $error("reduced variant ran a timer or counter opcode");
  rung_load_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    instr_i.valid && instr_i.op == lcc_pkg::LCC_OP_RUNG_LOAD
    |=> rung_q == $past(operand_i.bit_val))
    else $error("rung load did not take image bit");
  coil_wr_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    instr_i.valid && instr_i.op == lcc_pkg::LCC_OP_COIL
    |=> wr_o.valid && wr_o.data == $past(rung_q) && wr_o.addr == $past(instr_i.addr))
    else $error("coil write wrong");
  no_side_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !(instr_i.valid && instr_i.op == lcc_pkg::LCC_OP_COIL) |=> !wr_o.valid)
    else $error("image written by a combining opcode");

endmodule

// ==== bench/lcc_image_model.sv ====
// Image table and timer/counter store facing the combiner.
// Assumes the bench preloads the arrays and one instruction per scan clock.
`timescale 1ns/1ps
module lcc_image_model (
  // Clock
  input wire logic core_clk_i,
  // From the combiner side
  input wire lcc_pkg::lcc_instr_t instr_i,
  input wire lcc_pkg::lcc_write_t wr_i,
  // Operands
  output lcc_pkg::lcc_operand_t operand_o
);
  logic img [0:2047];
  logic [15:0] cur [0:63];
  logic [15:0] pre [0:63];

  // Timers and counters share one store, indexed by the low six address bits
  assign operand_o = {img[instr_i.addr], cur[instr_i.addr[5:0]], pre[instr_i.addr[5:0]]};

  // Coil writes land at the next edge, so the next read sees the old bit
  always @(posedge core_clk_i)
  begin
    if (wr_i.valid)
    begin
      img[wr_i.addr] <= wr_i.data;
    end
  end
endmodule

// ==== bench/ladder_contact_combiner_tb_top.sv ====
// Random contact programs run on a full and a reduced variant side by side.
// Assumes operands follow the instruction combinationally from the image model.
`timescale 1ns/1ps
module ladder_contact_combiner_tb_top;
  logic core_clk_i;
  logic rstn_i;
  lcc_pkg::lcc_instr_t instr;
  lcc_pkg::lcc_operand_t opnd;
  lcc_pkg::lcc_write_t wr_f;
  lcc_pkg::lcc_write_t wr_r;
  logic rung_f, rung_r, ill_f, ill_r;
  logic [18:0] notes [$];
  int miscompares = 0;
  int cmp_count = 0;

  lcc_combiner #(.VARIANT(lcc_pkg::VARIANT_FULL_B)) dut_u (.core_clk_i(core_clk_i),
    .rstn_i(rstn_i), .instr_i(instr), .operand_i(opnd), .rung_o(rung_f), .wr_o(wr_f),
    .illegal_o(ill_f));
  lcc_combiner #(.VARIANT(lcc_pkg::VARIANT_REDUCED)) dut_r (.core_clk_i(core_clk_i),
    .rstn_i(rstn_i), .instr_i(instr), .operand_i(opnd), .rung_o(rung_r), .wr_o(wr_r),
    .illegal_o(ill_r));
  lcc_image_model pm_u (.core_clk_i(core_clk_i), .instr_i(instr), .wr_i(wr_f),
    .operand_o(opnd));

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(string name, logic [10:0] exp, logic [10:0] got);
    cmp_count++;
    if (exp !== got)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Returns {rung, illegal, write valid, write data}
  function automatic logic [3:0] step(logic red, lcc_pkg::lcc_instr_t in,
    lcc_pkg::lcc_operand_t od, logic r);
    logic [3:0] op;
    logic c;
    logic tc;
    op = in.op;
    tc = op inside {[4'h4:4'h7], [4'hA:4'hD]};
    c = (tc ? od.cur >= od.preset : od.bit_val) ^ (op[0] && op > 4'h2);
    if (!in.valid)
      return {r, 3'b000};
    if (tc && (red || in.addr < lcc_pkg::TC_ADDR_LO || in.addr > lcc_pkg::TC_ADDR_HI))
      return {r, 3'b100};
    if (op == 4'h1)
      return {od.bit_val, 3'b000};
    if (op inside {[4'h2:4'h7]})
      return {r | c, 3'b000};
    if (op inside {[4'h8:4'hD]})
      return {r & c, 3'b000};
    if (op == 4'hE)
      return {r, 2'b01, r};
    return {r, 3'b000};
  endfunction

  initial
  begin
    logic rf;
    logic rr;
    logic [3:0] ef;
    logic [3:0] er;
    rf = 1'b0;
    rr = 1'b0;
    instr = '0;
    rstn_i = 1'b0;
    void'($urandom(32'h5E428BDB));
    for (int i = 0; i < 2048; i++)
      pm_u.img[i] = 1'($urandom);
    // Small values so that equal current and preset come up often
    for (int i = 0; i < 64; i++)
    begin
      pm_u.cur[i] = 16'($urandom % 4);
      pm_u.pre[i] = 16'($urandom % 4);
    end
    repeat (2) @(negedge core_clk_i);
    rstn_i = 1'b1;
    repeat (4000)
    begin
      instr.valid = ($urandom % 8) != 0;
      instr.op = lcc_pkg::lcc_op_t'(4'($urandom % 16));
      // Spans both edges of the timer/counter range
      instr.addr = 11'h170 + 11'($urandom % 96);
      #1;
      ef = step(1'b0, instr, opnd, rf);
      er = step(1'b1, instr, opnd, rr);
      rf = ef[3];
      rr = er[3];
      notes.push_back({instr.addr, ef, er});
      @(negedge core_clk_i);
    end
    test_done();
  end

  always @(posedge core_clk_i)
  begin
    logic [18:0] n;
    #1;
    if (notes.size() > 0)
    begin
      n = notes.pop_front();
      check("full result", 11'(n[7:4]), 11'({rung_f, ill_f, wr_f.valid, wr_f.data & wr_f.valid}));
      check("reduced result", 11'(n[3:0]), 11'({rung_r, ill_r, wr_r.valid, wr_r.data & wr_r.valid}));
      if (n[5])
        check("full write addr", n[18:8], wr_f.addr);
      if (n[1])
        check("reduced write addr", n[18:8], wr_r.addr);
    end
  end

  initial
  begin
    #100us;
    miscompares++;
    test_done();
  end
endmodule
